/* rtl/servo_cmd_pkg.sv */
// Package with constants, enumerations and types for the servo command selector.
package servo_cmd_pkg;

  // Clock period and derived counts.
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILTER_TIME_MS = 4;
  localparam int FILTER_CYCLES = (FILTER_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int MONITOR_DELAY_S = 2;
  localparam longint MONITOR_DELAY_CYCLES = (longint'(MONITOR_DELAY_S) * 64'd1000000000) / CLK_PERIOD_NS;

  // Control mode setting codes.
  localparam logic [15:0] MODE_SPEED_CODE = 16'h0002;
  localparam logic [15:0] MODE_TORQUE_CODE = 16'h0004;

  // Input filter setting code for the 4 ms time constant.
  localparam logic [15:0] FILTER_4MS_CODE = 16'h0002;

  // Reset value of the active mode, and of the torque limit, which is also its maximum.
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [6:0] TORQUE_LIMIT_MAX = 7'h64;

  // Register indices of the command port.
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_FILTER = 4'h1;
  localparam logic [3:0] ADDR_SPEED1 = 4'h2;
  localparam logic [3:0] ADDR_SPEED2 = 4'h3;
  localparam logic [3:0] ADDR_SPEED3 = 4'h4;
  localparam logic [3:0] ADDR_TLIMIT = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_ACTIVE_MODE = 4'h7;

  // Status word bit positions.
  localparam int ST_READY = 0;
  localparam int ST_ENERGIZE = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_DECEL = 3;
  localparam int ST_BRAKE = 4;
  localparam int ST_ALARM = 5;
  localparam int ST_DIR_CCW = 6;
  localparam int ST_DIR_CW = 7;
  localparam int ST_MONITOR = 8;

  // Number of filtered digital inputs.
  localparam int NUM_INPUTS = 10;

  // Index of each digital input in the filtered vector.
  localparam int IN_SERVO_ON = 0;
  localparam int IN_SEL0 = 1;
  localparam int IN_SEL1 = 2;
  localparam int IN_FWD = 3;
  localparam int IN_REV = 4;
  localparam int IN_TCCW = 5;
  localparam int IN_TCW = 6;
  localparam int IN_PLIM = 7;
  localparam int IN_NLIM = 8;
  localparam int IN_ESTOP = 9;

  typedef enum logic [1:0] {
    SRC_ANALOG = 2'b00,
    SRC_INNER1 = 2'b01,
    SRC_INNER2 = 2'b10,
    SRC_INNER3 = 2'b11
  } speed_src_e;

  typedef enum logic [2:0] {
    RUN_OFF = 3'b000,
    RUN_LOCK = 3'b001,
    RUN_CCW = 3'b010,
    RUN_CW = 3'b011,
    RUN_DECEL = 3'b100,
    RUN_FREE = 3'b101,
    RUN_BRAKE = 3'b110
  } run_state_e;

endpackage : servo_cmd_pkg

/* rtl/input_filter_if.sv */
// Interface carrying raw and filtered digital inputs with the filter setting.
`timescale 1ns/10ps
interface input_filter_if #(parameter int WIDTH = 10);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  logic [31:0] filterCycles;
  modport filter (input raw, input filterCycles, output clean);
  modport user (output raw, output filterCycles, input clean);
endinterface : input_filter_if

/* rtl/input_filter.sv */
// Synchroniser and debounce filter for the digital input terminals.
`timescale 1ns/10ps
module input_filter #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Input vector
  input_filter_if.filter bus
);
  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] clean;
    logic [WIDTH-1:0][31:0] count;
  } filt_s;

  filt_s state;
  filt_s next_state;

  always_comb begin
    next_state = state;
    next_state.sync1 = bus.raw;
    next_state.sync2 = state.sync1;
    for (int i = 0; i < WIDTH; i++) begin
      if (state.sync2[i] == state.clean[i]) begin
        next_state.count[i] = 32'h0;
      end else if (state.count[i] + 32'h1 >= bus.filterCycles) begin
        next_state.clean[i] = state.sync2[i];
        next_state.count[i] = 32'h0;
      end else begin
        next_state.count[i] = state.count[i] + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bus.clean = state.clean;
endmodule : input_filter

/* rtl/servo_cmd_select.sv */
// Run and stop sequencing with command source selection for speed and torque modes.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
//
// Contract
// - In speed mode the select bits pick analog, inner speed 1, 2 or 3 for codes 00, 01, 10, 11.
// - In speed mode forward-only runs counter-clockwise, reverse-only clockwise, both or neither holds servo lock unless the motor was running.
// - Both start inputs on or both off decelerate the motor to a stop instead of halting abruptly.
// - In speed mode servo-on makes the drive ready, energizes the motor and enters servo lock.
// - In torque mode servo-on makes the drive ready but leaves the motor unenergized and free.
// - Releasing servo-on stops driving the motor and leaves the shaft free without braking.
// - Any alarm engages the dynamic brake and stops the motor abruptly.
// - Emergency stop going inactive acts as an alarm and also shows the alarm indication.
// - Each travel limit allows rotation in its direction only while asserted, otherwise the dynamic brake engages.
// - In torque mode the first torque-direction input drives counter-clockwise and the second clockwise.
// - In torque mode the select bits choose the speed limit source with the speed-mode encoding.
// - Two seconds after power-up the display switches to motor speed or torque command voltage per mode.
// - Mode code 0004 selects torque mode and a new mode setting takes effect only after a power cycle; reset restores 0002, so speed mode is always active.
// - Filter setting 0002 gives the input filters a 4 ms time constant.
// - The first inner torque limit is a percentage of maximum torque, so 50 gives half torque.
// - A digital input reads 1 when shorted to signal ground and 0 when open.
module servo_cmd_select
  import servo_cmd_pkg::*;
#(
  parameter longint MONITOR_CYCLES = MONITOR_DELAY_CYCLES,
  parameter int FILTER_COUNT = FILTER_CYCLES,
  parameter int SPEED_WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Digital input terminals, low when shorted to signal ground
  input wire logic servo_on_input_n,
  input wire logic speed_select_bit0_n,
  input wire logic speed_select_bit1_n,
  input wire logic forward_start_input_n,
  input wire logic reverse_start_input_n,
  input wire logic torque_ccw_select_n,
  input wire logic torque_cw_select_n,
  input wire logic positive_travel_limit_n,
  input wire logic negative_travel_limit_n,
  input wire logic emergency_stop_input_n,
  // Internal fault and analog command
  input wire logic faultIn,
  input wire logic [SPEED_WIDTH-1:0] analog_speed_command,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // Drive outputs
  output logic driveReady,
  output logic motorEnergize,
  output logic servoLock,
  output logic decelStop,
  output logic dynamicBrake,
  output logic dirCcw,
  output logic dirCw,
  output logic alarm_indication,
  output logic [SPEED_WIDTH-1:0] speedCommand,
  output logic [1:0] speedSource,
  output logic [6:0] torqueLimit,
  output logic torqueMode,
  output logic monitorDefault,
  output logic monitorTorque
);

  typedef struct packed {
    logic [15:0] modeSetting;
    logic [15:0] filterSetting;
    logic [15:0] inner1;
    logic [15:0] inner2;
    logic [15:0] inner3;
    logic [6:0] tlimit;
    logic [15:0] activeMode;
    logic [15:0] activeFilter;
    logic started;
    logic [63:0] monCount;
    logic monDone;
    run_state_e run;
    logic alarmLatched;
    logic [SPEED_WIDTH-1:0] speed;
    logic [1:0] src;
    logic [15:0] rdData;
    logic outReady;
    logic outEnergize;
    logic outLock;
    logic outDecel;
    logic outBrake;
    logic outCcw;
    logic outCw;
    logic outTorque;
    logic outMonTorque;
  } top_s;

  top_s state;
  top_s next_state;
  logic [NUM_INPUTS-1:0] din;
  logic [15:0] statusWord;

  input_filter_if #(.WIDTH(NUM_INPUTS)) filt ();

  // Shorted to ground is the active state, so the terminals are inverted.
  assign filt.raw = ~{emergency_stop_input_n, negative_travel_limit_n, positive_travel_limit_n,
                      torque_cw_select_n, torque_ccw_select_n, reverse_start_input_n,
                      forward_start_input_n, speed_select_bit1_n, speed_select_bit0_n,
                      servo_on_input_n};
  assign filt.filterCycles = (state.activeFilter == FILTER_4MS_CODE) ? 32'(FILTER_COUNT) : 32'h1;

  input_filter #(.WIDTH(NUM_INPUTS)) u_filter (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .bus(filt.filter)
  );

  assign din = filt.clean;

  always_comb begin
    logic isTorque;
    logic fault;
    logic fwd;
    logic rev;
    isTorque = 1'b0;
    fault = 1'b0;
    fwd = 1'b0;
    rev = 1'b0;
    next_state = state;

    // Settings written over the register port.
    if (regWr) begin
      case (regAddr)
        ADDR_MODE: begin
          next_state.modeSetting = regWrData;
        end
        ADDR_FILTER: begin
          next_state.filterSetting = regWrData;
        end
        ADDR_SPEED1: begin
          next_state.inner1 = regWrData;
        end
        ADDR_SPEED2: begin
          next_state.inner2 = regWrData;
        end
        ADDR_SPEED3: begin
          next_state.inner3 = regWrData;
        end
        ADDR_TLIMIT: begin
          next_state.tlimit = (regWrData > 16'(TORQUE_LIMIT_MAX)) ? TORQUE_LIMIT_MAX : regWrData[6:0];
        end
        ADDR_STATUS, ADDR_ACTIVE_MODE: begin
          // Status and the active mode are read-only, so writes to them are dropped.
        end
        default: begin
        end
      endcase
    end

    // Mode and filter settings are captured once after reset release only.
    if (!state.started) begin
      next_state.started = 1'b1;
      next_state.activeMode = state.modeSetting;
      next_state.activeFilter = state.filterSetting;
    end

    isTorque = (state.activeMode == MODE_TORQUE_CODE);

    // Default monitor switch after the power-up delay.
    if (!state.monDone) begin
      if (state.monCount + 64'h1 >= 64'(MONITOR_CYCLES)) begin
        next_state.monDone = 1'b1;
      end else begin
        next_state.monCount = state.monCount + 64'h1;
      end
    end

    // Source selection shared by speed command and torque speed limit.
    next_state.src = {din[IN_SEL1], din[IN_SEL0]};
    case (speed_src_e'({din[IN_SEL1], din[IN_SEL0]}))
      SRC_ANALOG: begin
        next_state.speed = analog_speed_command;
      end
      SRC_INNER1: begin
        next_state.speed = SPEED_WIDTH'(state.inner1);
      end
      SRC_INNER2: begin
        next_state.speed = SPEED_WIDTH'(state.inner2);
      end
      SRC_INNER3: begin
        next_state.speed = SPEED_WIDTH'(state.inner3);
      end
      default: begin
        next_state.speed = analog_speed_command;
      end
    endcase

    // Direction requests and travel limits.
    if (isTorque) begin
      fwd = din[IN_TCCW] & ~din[IN_TCW];
      rev = din[IN_TCW] & ~din[IN_TCCW];
    end else begin
      fwd = din[IN_FWD] & ~din[IN_REV];
      rev = din[IN_REV] & ~din[IN_FWD];
    end

    // Alarm and emergency stop both brake, and both raise the indication.
    fault = faultIn | ~din[IN_ESTOP];
    next_state.alarmLatched = ~din[IN_ESTOP] | faultIn;

    if (fault) begin
      next_state.run = RUN_BRAKE;
    end else if (!din[IN_SERVO_ON]) begin
      next_state.run = RUN_OFF;
    end else if ((fwd && !din[IN_PLIM]) || (rev && !din[IN_NLIM])) begin
      next_state.run = RUN_BRAKE;
    end else if (fwd) begin
      next_state.run = RUN_CCW;
    end else if (rev) begin
      next_state.run = RUN_CW;
    end else if (isTorque) begin
      next_state.run = RUN_FREE;
    end else begin
      case (state.run)
        RUN_CCW, RUN_CW, RUN_DECEL: begin
          next_state.run = RUN_DECEL;
        end
        default: begin
          next_state.run = RUN_LOCK;
        end
      endcase
    end

    // Drive outputs are decoded from the next run state, active mode and monitor flag so that they leave flip-flops.
    next_state.outReady = (next_state.run != RUN_OFF) && (next_state.run != RUN_BRAKE);
    next_state.outEnergize = (next_state.run == RUN_LOCK) || (next_state.run == RUN_CCW) ||
                             (next_state.run == RUN_CW) || (next_state.run == RUN_DECEL);
    next_state.outLock = (next_state.run == RUN_LOCK);
    next_state.outDecel = (next_state.run == RUN_DECEL);
    next_state.outBrake = (next_state.run == RUN_BRAKE);
    next_state.outCcw = (next_state.run == RUN_CCW);
    next_state.outCw = (next_state.run == RUN_CW);
    next_state.outTorque = (next_state.activeMode == MODE_TORQUE_CODE);
    next_state.outMonTorque = next_state.monDone && (next_state.activeMode == MODE_TORQUE_CODE);

    // Read data stand in the cycle after the read strobe.
    next_state.rdData = 16'h0000;
    if (regRd) begin
      case (regAddr)
        ADDR_MODE: begin
          next_state.rdData = state.modeSetting;
        end
        ADDR_FILTER: begin
          next_state.rdData = state.filterSetting;
        end
        ADDR_SPEED1: begin
          next_state.rdData = state.inner1;
        end
        ADDR_SPEED2: begin
          next_state.rdData = state.inner2;
        end
        ADDR_SPEED3: begin
          next_state.rdData = state.inner3;
        end
        ADDR_TLIMIT: begin
          next_state.rdData = {9'h000, state.tlimit};
        end
        ADDR_STATUS: begin
          next_state.rdData = statusWord;
        end
        ADDR_ACTIVE_MODE: begin
          next_state.rdData = state.activeMode;
        end
        default: begin
          next_state.rdData = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state.modeSetting <= MODE_SPEED_CODE;
      state.filterSetting <= FILTER_4MS_CODE;
      state.inner1 <= 16'h0000;
      state.inner2 <= 16'h0000;
      state.inner3 <= 16'h0000;
      state.tlimit <= TORQUE_LIMIT_MAX;
      state.activeMode <= MODE_RESET;
      state.activeFilter <= FILTER_4MS_CODE;
      state.started <= 1'b0;
      state.monCount <= 64'h0;
      state.monDone <= 1'b0;
      state.run <= RUN_OFF;
      state.alarmLatched <= 1'b0;
      state.speed <= '0;
      state.src <= 2'h0;
      state.rdData <= 16'h0000;
      state.outReady <= 1'b0;
      state.outEnergize <= 1'b0;
      state.outLock <= 1'b0;
      state.outDecel <= 1'b0;
      state.outBrake <= 1'b0;
      state.outCcw <= 1'b0;
      state.outCw <= 1'b0;
      state.outTorque <= 1'b0;
      state.outMonTorque <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Registered drive outputs; the first seven are decoded from the run state.
  assign driveReady = state.outReady;
  assign motorEnergize = state.outEnergize;
  assign servoLock = state.outLock;
  assign decelStop = state.outDecel;
  assign dynamicBrake = state.outBrake;
  assign dirCcw = state.outCcw;
  assign dirCw = state.outCw;
  assign alarm_indication = state.alarmLatched;
  assign speedCommand = state.speed;
  assign speedSource = state.src;
  assign torqueLimit = state.tlimit;
  assign torqueMode = state.outTorque;
  assign monitorDefault = state.monDone;
  assign monitorTorque = state.outMonTorque;
  assign regRdData = state.rdData;

  always_comb begin
    statusWord = 16'h0000;
    statusWord[ST_READY] = driveReady;
    statusWord[ST_ENERGIZE] = motorEnergize;
    statusWord[ST_LOCK] = servoLock;
    statusWord[ST_DECEL] = decelStop;
    statusWord[ST_BRAKE] = dynamicBrake;
    statusWord[ST_ALARM] = alarm_indication;
    statusWord[ST_DIR_CCW] = dirCcw;
    statusWord[ST_DIR_CW] = dirCw;
    statusWord[ST_MONITOR] = monitorDefault;
  end

endmodule : servo_cmd_select

/* testbench/servo_cmd_monitor.sv */
// Checker of the drive outputs of the servo command selector.
`timescale 1ns/10ps
module servo_cmd_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Watched ports
  input wire logic faultIn,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic driveReady,
  input wire logic motorEnergize,
  input wire logic servoLock,
  input wire logic dynamicBrake,
  input wire logic dirCcw,
  input wire logic dirCw,
  input wire logic [6:0] torqueLimit,
  input wire logic torqueMode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_fault_brakes: assert property (faultIn |-> ##[1:3] dynamicBrake)
    else $error("Fault did not engage the brake.");
  a_brake_stops_run: assert property (dynamicBrake |-> !dirCcw && !dirCw)
    else $error("Direction active while braking.");
  a_dir_exclusive: assert property (!(dirCcw && dirCw))
    else $error("Both directions active.");
  a_run_ready: assert property ((dirCcw || dirCw) |-> driveReady && motorEnergize)
    else $error("Running without ready and energized motor.");
  a_lock_energized: assert property (servoLock |-> driveReady && motorEnergize && !dynamicBrake)
    else $error("Servo lock without energized motor.");
  a_off_free: assert property (!driveReady |-> !motorEnergize && !servoLock && !dirCcw && !dirCw)
    else $error("Motor driven while not ready.");
  a_torque_idle_free: assert property (torqueMode && driveReady && !dirCcw && !dirCw && !dynamicBrake |->
    !motorEnergize)
    else $error("Idle torque mode energizes the motor.");
  a_limit_clamped: assert property (torqueLimit <= 7'h64)
    else $error("Torque limit above full torque.");
  a_mode_fixed: assert property ($past(arst_n, 2) |-> $stable(torqueMode))
    else $error("Active mode changed without a reset.");
  a_read_idle_zero: assert property (!regRd |=> regRdData == 16'h0000)
    else $error("Read data outside the answer cycle.");
endmodule : servo_cmd_monitor

bind servo_cmd_select servo_cmd_monitor servo_cmd_monitor_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .faultIn(faultIn), .regRd(regRd), .regRdData(regRdData), .driveReady(driveReady),
  .motorEnergize(motorEnergize), .servoLock(servoLock), .dynamicBrake(dynamicBrake), .dirCcw(dirCcw),
  .dirCw(dirCw), .torqueLimit(torqueLimit), .torqueMode(torqueMode));

/* testbench/controller_model.sv */
// Model of the external controller that closes contacts on the terminals.
`timescale 1ns/10ps
module controller_model
  import servo_cmd_pkg::*;
(
  // Closed contacts
  input wire logic [NUM_INPUTS-1:0] closed,
  // Terminal pins
  output logic servo_on_input_n,
  output logic speed_select_bit0_n,
  output logic speed_select_bit1_n,
  output logic forward_start_input_n,
  output logic reverse_start_input_n,
  output logic torque_ccw_select_n,
  output logic torque_cw_select_n,
  output logic positive_travel_limit_n,
  output logic negative_travel_limit_n,
  output logic emergency_stop_input_n
);
  // A closed contact pulls its terminal to signal ground.
  assign servo_on_input_n = !closed[IN_SERVO_ON];
  assign speed_select_bit0_n = !closed[IN_SEL0];
  assign speed_select_bit1_n = !closed[IN_SEL1];
  assign forward_start_input_n = !closed[IN_FWD];
  assign reverse_start_input_n = !closed[IN_REV];
  assign torque_ccw_select_n = !closed[IN_TCCW];
  assign torque_cw_select_n = !closed[IN_TCW];
  assign positive_travel_limit_n = !closed[IN_PLIM];
  assign negative_travel_limit_n = !closed[IN_NLIM];
  assign emergency_stop_input_n = !closed[IN_ESTOP];
endmodule : controller_model

/* testbench/tb.sv */
// Testbench of the servo command selector.
`timescale 1ns/10ps
module tb
  import servo_cmd_pkg::*;
;
  logic clk_sys, arst_n, faultIn, regWr, regRd;
  logic [15:0] analog, regWrData, regRdData, speedCommand;
  logic [3:0] regAddr;
  logic [NUM_INPUTS-1:0] closed;
  logic [9:0] pin;
  logic driveReady, motorEnergize, servoLock, decelStop, dynamicBrake, dirCcw, dirCw, alarmSeen;
  logic torqueMode, monitorDefault, monitorTorque;
  logic [1:0] speedSource;
  logic [6:0] torqueLimit;
  localparam int FILT = 16;
  int nErrors = 0;
  int checked = 0;

  controller_model controller_model_i (.closed(closed), .servo_on_input_n(pin[0]), .speed_select_bit0_n(pin[1]),
    .speed_select_bit1_n(pin[2]), .forward_start_input_n(pin[3]), .reverse_start_input_n(pin[4]),
    .torque_ccw_select_n(pin[5]), .torque_cw_select_n(pin[6]), .positive_travel_limit_n(pin[7]),
    .negative_travel_limit_n(pin[8]), .emergency_stop_input_n(pin[9]));

  servo_cmd_select #(.MONITOR_CYCLES(100), .FILTER_COUNT(FILT)) servo_cmd_select_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .servo_on_input_n(pin[0]), .speed_select_bit0_n(pin[1]), .speed_select_bit1_n(pin[2]),
    .forward_start_input_n(pin[3]), .reverse_start_input_n(pin[4]), .torque_ccw_select_n(pin[5]),
    .torque_cw_select_n(pin[6]), .positive_travel_limit_n(pin[7]), .negative_travel_limit_n(pin[8]),
    .emergency_stop_input_n(pin[9]), .faultIn(faultIn), .analog_speed_command(analog), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .driveReady(driveReady),
    .motorEnergize(motorEnergize), .servoLock(servoLock), .decelStop(decelStop), .dynamicBrake(dynamicBrake),
    .dirCcw(dirCcw), .dirCw(dirCw), .alarm_indication(alarmSeen), .speedCommand(speedCommand),
    .speedSource(speedSource), .torqueLimit(torqueLimit), .torqueMode(torqueMode),
    .monitorDefault(monitorDefault), .monitorTorque(monitorTorque));

  always #4 clk_sys = ~clk_sys;

  task complete_run;
    if (nErrors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1;
    cmp($sformatf("reg %h", a), exp, regRdData);
  endtask : rd

  initial begin
    repeat (40 * (FILT + 20)) @(posedge clk_sys);
    nErrors++;
    complete_run;
  end

  initial begin
    clk_sys = 1'h0;
    arst_n = 1'h0;
    faultIn = 1'h0;
    analog = 16'h1234;
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWr = 1'h0;
    regRd = 1'h0;
    closed = '0;
    closed[IN_PLIM] = 1'h1;
    closed[IN_NLIM] = 1'h1;
    closed[IN_ESTOP] = 1'h1;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'h1;
    repeat (120) @(posedge clk_sys);
    #1;
    cmp("monitorDefault", 16'h0001, 16'(monitorDefault));
    cmp("monitorTorque", 16'h0000, 16'(monitorTorque));
    rd(ADDR_FILTER, FILTER_4MS_CODE);
    rd(ADDR_TLIMIT, 16'h0064);
    wr(ADDR_TLIMIT, 16'h0032);
    rd(ADDR_TLIMIT, 16'h0032);
    cmp("torqueLimit", 16'h0032, 16'(torqueLimit));
    wr(ADDR_TLIMIT, 16'h00C8);
    rd(ADDR_TLIMIT, 16'h0064);
    wr(ADDR_MODE, MODE_TORQUE_CODE);
    rd(ADDR_MODE, MODE_TORQUE_CODE);
    rd(ADDR_ACTIVE_MODE, MODE_SPEED_CODE);
    cmp("torqueMode", 16'h0000, 16'(torqueMode));
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    wr(ADDR_SPEED1, 16'h03E8);
    wr(ADDR_SPEED2, 16'h05DC);
    wr(ADDR_SPEED3, 16'h07D0);
    rd(ADDR_SPEED1, 16'h03E8);
    rd(ADDR_SPEED3, 16'h07D0);
    @(posedge clk_sys);
    closed[IN_SERVO_ON] <= 1'h1;
    closed[IN_SEL0] <= 1'h1;
    closed[IN_FWD] <= 1'h1;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("driveReady", 16'h0001, 16'(driveReady));
    cmp("motorEnergize", 16'h0001, 16'(motorEnergize));
    cmp("dirCcw", 16'h0001, 16'(dirCcw));
    cmp("dirCw", 16'h0000, 16'(dirCw));
    cmp("speedSource", 16'(SRC_INNER1), 16'(speedSource));
    cmp("speedCommand", 16'h03E8, speedCommand);
    cmp("dynamicBrake", 16'h0000, 16'(dynamicBrake));
    @(posedge clk_sys);
    faultIn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp("dynamicBrake", 16'h0001, 16'(dynamicBrake));
    cmp("dirCcw", 16'h0000, 16'(dirCcw));
    @(posedge clk_sys);
    faultIn <= 1'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    cmp("dirCcw", 16'h0001, 16'(dirCcw));
    cmp("alarm_indication", 16'h0000, 16'(alarmSeen));
    @(posedge clk_sys);
    closed[IN_FWD] <= 1'h0;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("decelStop", 16'h0001, 16'(decelStop));
    cmp("servoLock", 16'h0000, 16'(servoLock));
    @(posedge clk_sys);
    closed[IN_FWD] <= 1'h1;
    closed[IN_REV] <= 1'h1;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("decelStop", 16'h0001, 16'(decelStop));
    cmp("dirCcw", 16'h0000, 16'(dirCcw));
    @(posedge clk_sys);
    closed[IN_FWD] <= 1'h0;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("dirCw", 16'h0001, 16'(dirCw));
    cmp("decelStop", 16'h0000, 16'(decelStop));
    @(posedge clk_sys);
    closed[IN_NLIM] <= 1'h0;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("dynamicBrake", 16'h0001, 16'(dynamicBrake));
    cmp("dirCw", 16'h0000, 16'(dirCw));
    cmp("alarm_indication", 16'h0000, 16'(alarmSeen));
    @(posedge clk_sys);
    closed[IN_NLIM] <= 1'h1;
    closed[IN_REV] <= 1'h0;
    closed[IN_SEL0] <= 1'h0;
    closed[IN_SEL1] <= 1'h1;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("servoLock", 16'h0001, 16'(servoLock));
    cmp("motorEnergize", 16'h0001, 16'(motorEnergize));
    cmp("speedSource", 16'(SRC_INNER2), 16'(speedSource));
    cmp("speedCommand", 16'h05DC, speedCommand);
    rd(ADDR_STATUS, 16'h0107);
    @(posedge clk_sys);
    closed[IN_ESTOP] <= 1'h0;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("dynamicBrake", 16'h0001, 16'(dynamicBrake));
    cmp("alarm_indication", 16'h0001, 16'(alarmSeen));
    @(posedge clk_sys);
    closed[IN_ESTOP] <= 1'h1;
    closed[IN_SERVO_ON] <= 1'h0;
    closed[IN_SEL1] <= 1'h0;
    repeat (FILT + 20) @(posedge clk_sys);
    #1;
    cmp("driveReady", 16'h0000, 16'(driveReady));
    cmp("motorEnergize", 16'h0000, 16'(motorEnergize));
    cmp("dynamicBrake", 16'h0000, 16'(dynamicBrake));
    cmp("alarm_indication", 16'h0000, 16'(alarmSeen));
    cmp("speedCommand", 16'h1234, speedCommand);
    rd(ADDR_STATUS, 16'h0100);
    complete_run;
  end
endmodule : tb
